// File: cmp_monitor_pkg.sv
// How it works
// - enable bits b0, b4 switch channels
// - monitor flags b3, b7 show result
// - two identical independent channel paths
// - result change raises channel request
// - input enable bits b2, b6 gate requests
// - both-edge bits b3, b7 select edges
// - enable register write may raise request
// - two-bit filter select per channel
// - filter needs three matching samples
// - request, level, polarity shared with pin
package cmp_monitor_pkg;

    // byte addresses of the registers on the bus
    localparam logic [11:0] CONTROL_ADDR      = 12'h1F8;
    localparam logic [11:0] FILTER_ADDR       = 12'h1FC;
    localparam logic [11:0] INPUT_ENABLE_ADDR = 12'h200;
    localparam logic [11:0] IRQ_CONTROL_ADDR  = 12'h204;
    localparam logic [11:0] IRQ_STATUS_ADDR   = 12'h208;
    localparam logic [11:0] IRQ_MASK_ADDR     = 12'h20C;

    // field positions in comparator_control
    localparam int CH1_ENABLE_BIT = 0;
    localparam int CH1_RESULT_BIT = 3;
    localparam int CH3_ENABLE_BIT = 4;
    localparam int CH3_RESULT_BIT = 7;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'h11;

    // field positions in external_input_enable
    localparam int PIN0_IRQ_EN_BIT = 0;
    localparam int PIN0_BOTH_BIT   = 1;
    localparam int CH1_IRQ_EN_BIT  = 2;
    localparam int CH1_BOTH_BIT    = 3;
    localparam int CH3_IRQ_EN_BIT  = 6;
    localparam int CH3_BOTH_BIT    = 7;
    localparam logic [7:0] INPUT_ENABLE_WRITE_MASK = 8'hCF;

    // filter select fields in input_filter_select
    localparam int CH1_FILTER_LSB = 2;
    localparam int CH3_FILTER_LSB = 6;
    localparam logic [7:0] FILTER_WRITE_MASK = 8'hCF;

    // irq_control_register layout, one per channel, shared with pin
    localparam int IRQ_LEVEL_LSB   = 0;
    localparam int IRQ_REQUEST_BIT = 3;
    localparam int IRQ_POLARITY_BIT = 4;

    // reset values
    localparam logic [7:0] CONTROL_RESET      = 8'h00;
    localparam logic [7:0] FILTER_RESET       = 8'h00;
    localparam logic [7:0] INPUT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] IRQ_CONTROL_RESET  = 8'h00;

    // sampling prescale divisors for f8 and f32
    localparam int DIV_F8  = 8;
    localparam int DIV_F32 = 32;
    localparam int FILTER_MATCH_COUNT = 3;

    typedef enum logic [1:0]
    {
        FILTER_OFF = 2'b00,
        FILTER_F1  = 2'b01,
        FILTER_F8  = 2'b10,
        FILTER_F32 = 2'b11
    } filter_sel_t;

    // per-channel configuration bundle
    typedef struct packed
    {
        logic        enable;
        logic        irqEnable;
        logic        edgeBoth;
        logic        polarityRising;
        filter_sel_t filterSel;
    } channel_cfg_t;

endpackage : cmp_monitor_pkg

// File: cmp_channel.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_channel
    import cmp_monitor_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    // configuration
    input  wire channel_cfg_t  cfg,
    input  wire logic          tickF8,
    input  wire logic          tickF32,
    // analog comparator output, asynchronous
    input  wire logic          compOut,
    // results
    output logic               resultFlag,
    output logic               edgeEvent
);

    logic       syncStage1_reg;
    logic       syncStage2_reg;
    logic [1:0] sampleHist_reg;
    logic       level_reg;
    logic       sampleTick;
    logic       levelIn;
    logic       levelNext;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncStage1_reg <= 1'b0;
            syncStage2_reg <= 1'b0;
        end
        else
        begin
            syncStage1_reg <= compOut;
            syncStage2_reg <= syncStage1_reg;
        end
    end

    assign levelIn = cfg.enable & syncStage2_reg;

    always_comb
    begin
        unique case (cfg.filterSel)
            FILTER_OFF: sampleTick = 1'b1;
            FILTER_F1:  sampleTick = 1'b1;
            FILTER_F8:  sampleTick = tickF8;
            FILTER_F32: sampleTick = tickF32;
        endcase
    end

    // accept level after three equal samples
    always_comb
    begin
        levelNext = level_reg;
        if (cfg.filterSel == FILTER_OFF)
            levelNext = levelIn;
        else if (sampleTick && sampleHist_reg[0] == levelIn && sampleHist_reg[1] == levelIn)
            levelNext = levelIn;
    end

    // sample history and accepted level
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sampleHist_reg <= 2'b00;
            level_reg      <= 1'b0;
        end
        else
        begin
            if (sampleTick)
                sampleHist_reg <= {sampleHist_reg[0], levelIn};
            level_reg <= levelNext;
        end
    end

    // monitor flag shows the synchronized result, unfiltered
    assign resultFlag = levelIn;

    // one edge by polarity, or both edges
    always_comb
    begin
        edgeEvent = 1'b0;
        if (levelNext != level_reg)
        begin
            if (cfg.edgeBoth)
                edgeEvent = 1'b1;
            else
                edgeEvent = (levelNext == cfg.polarityRising);
        end
    end

endmodule : cmp_channel
`default_nettype wire

// File: cmp_monitor.sv
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module cmp_monitor
    import cmp_monitor_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator outputs
    input  wire logic        channel1CompOut,
    input  wire logic        channel3CompOut,
    // analog enables to the comparators
    output logic             channel1Enable,
    output logic             channel3Enable,
    // interrupt controller side
    output logic             channel1Request,
    output logic             channel3Request,
    output logic [2:0]       channel1Level,
    output logic [2:0]       channel3Level,
    output logic             irq
);

    logic [7:0]   control_reg;
    logic [7:0]   filter_reg;
    logic [7:0]   inputEnable_reg;
    logic [7:0]   irqCtl1_reg;
    logic [7:0]   irqCtl3_reg;
    logic [1:0]   status_reg;
    logic [1:0]   mask_reg;
    logic [4:0]   prescale_reg;
    logic         tickF8;
    logic         tickF32;
    logic         wrAccess;
    logic         wrLow;
    logic         enableWrite;
    logic         ch1Flag;
    logic         ch3Flag;
    logic         ch1Event;
    logic         ch3Event;
    logic         ch1Req;
    logic         ch3Req;
    logic         addrHit;
    channel_cfg_t cfg1;
    channel_cfg_t cfg3;

    // zero-wait slave; writes need byte lane 0
    assign pready   = 1'b1;
    assign wrAccess = psel & penable & pwrite;
    assign wrLow    = wrAccess & pstrb[0];
    assign addrHit  = (paddr == CONTROL_ADDR) || (paddr == FILTER_ADDR)
                   || (paddr == INPUT_ENABLE_ADDR) || (paddr == IRQ_CONTROL_ADDR)
                   || (paddr == IRQ_STATUS_ADDR) || (paddr == IRQ_MASK_ADDR);
    assign pslverr  = psel & penable & ~addrHit;

    // enable bits write; result bits read-only
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            control_reg <= CONTROL_RESET;
        else if (wrLow && paddr == CONTROL_ADDR)
            control_reg <= pwdata[7:0] & CONTROL_WRITE_MASK;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            filter_reg <= FILTER_RESET;
        else if (wrLow && paddr == FILTER_ADDR)
            filter_reg <= pwdata[7:0] & FILTER_WRITE_MASK;
    end

    assign enableWrite = wrLow && paddr == INPUT_ENABLE_ADDR;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            inputEnable_reg <= INPUT_ENABLE_RESET;
        else if (enableWrite)
            inputEnable_reg <= pwdata[7:0] & INPUT_ENABLE_WRITE_MASK;
    end

    // shared sampling prescaler, free running for f8 and f32
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            prescale_reg <= 5'h00;
        else
            prescale_reg <= prescale_reg + 5'h01;
    end
    assign tickF8  = (prescale_reg[2:0] == 3'(DIV_F8 - 1));
    assign tickF32 = (prescale_reg == 5'(DIV_F32 - 1));

    assign cfg1.enable         = control_reg[CH1_ENABLE_BIT];
    assign cfg1.irqEnable      = inputEnable_reg[CH1_IRQ_EN_BIT];
    assign cfg1.edgeBoth       = inputEnable_reg[CH1_BOTH_BIT];
    assign cfg1.polarityRising = irqCtl1_reg[IRQ_POLARITY_BIT];
    assign cfg1.filterSel      = filter_sel_t'(filter_reg[CH1_FILTER_LSB +: 2]);
    assign cfg3.enable         = control_reg[CH3_ENABLE_BIT];
    assign cfg3.irqEnable      = inputEnable_reg[CH3_IRQ_EN_BIT];
    assign cfg3.edgeBoth       = inputEnable_reg[CH3_BOTH_BIT];
    assign cfg3.polarityRising = irqCtl3_reg[IRQ_POLARITY_BIT];
    assign cfg3.filterSel      = filter_sel_t'(filter_reg[CH3_FILTER_LSB +: 2]);

    cmp_channel u_channel1
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .cfg        (cfg1),
        .tickF8     (tickF8),
        .tickF32    (tickF32),
        .compOut    (channel1CompOut),
        .resultFlag (ch1Flag),
        .edgeEvent  (ch1Event)
    );

    cmp_channel u_channel3
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .cfg        (cfg3),
        .tickF8     (tickF8),
        .tickF32    (tickF32),
        .compOut    (channel3CompOut),
        .resultFlag (ch3Flag),
        .edgeEvent  (ch3Event)
    );

    // enable register write raises request when it sets a channel's input enable bit (b2, b6)
    assign ch1Req = (cfg1.irqEnable & ch1Event) | (enableWrite & pwdata[CH1_IRQ_EN_BIT]);
    assign ch3Req = (cfg3.irqEnable & ch3Event) | (enableWrite & pwdata[CH3_IRQ_EN_BIT]);

    // shared control: level, request, polarity; set wins over clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqCtl1_reg <= IRQ_CONTROL_RESET;
            irqCtl3_reg <= IRQ_CONTROL_RESET;
        end
        else
        begin
            if (wrLow && paddr == IRQ_CONTROL_ADDR)
            begin
                irqCtl1_reg <= {3'h0, pwdata[4:0]};
                irqCtl3_reg <= {3'h0, pwdata[12:8]};
            end
            if (ch1Req)
                irqCtl1_reg[IRQ_REQUEST_BIT] <= 1'b1;
            if (ch3Req)
                irqCtl3_reg[IRQ_REQUEST_BIT] <= 1'b1;
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            status_reg <= 2'b00;
        else
        begin
            if (wrLow && paddr == IRQ_STATUS_ADDR)
                status_reg <= status_reg & ~pwdata[1:0];
            if (ch1Req)
                status_reg[0] <= 1'b1;
            if (ch3Req)
                status_reg[1] <= 1'b1;
        end
    end

    // interrupt mask register
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            mask_reg <= 2'b00;
        else if (wrLow && paddr == IRQ_MASK_ADDR)
            mask_reg <= pwdata[1:0];
    end

    assign irq = |(status_reg & mask_reg);

    // outputs to analog and interrupt controller
    assign channel1Enable  = control_reg[CH1_ENABLE_BIT];
    assign channel3Enable  = control_reg[CH3_ENABLE_BIT];
    assign channel1Request = irqCtl1_reg[IRQ_REQUEST_BIT];
    assign channel3Request = irqCtl3_reg[IRQ_REQUEST_BIT];
    assign channel1Level   = irqCtl1_reg[IRQ_LEVEL_LSB +: 3];
    assign channel3Level   = irqCtl3_reg[IRQ_LEVEL_LSB +: 3];

    // read mux with live monitor flags
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite)
        begin
            unique case (paddr)
                CONTROL_ADDR:
                begin
                    prdata[7:0] = control_reg;
                    prdata[CH1_RESULT_BIT] = ch1Flag;
                    prdata[CH3_RESULT_BIT] = ch3Flag;
                end
                FILTER_ADDR:       prdata[7:0] = filter_reg;
                INPUT_ENABLE_ADDR: prdata[7:0] = inputEnable_reg;
                IRQ_CONTROL_ADDR:  prdata[15:0] = {irqCtl3_reg, irqCtl1_reg};
                IRQ_STATUS_ADDR:   prdata[1:0] = status_reg;
                IRQ_MASK_ADDR:     prdata[1:0] = mask_reg;
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule : cmp_monitor
`default_nettype wire

// File: cmp_monitor_checker.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_monitor_checker
    import cmp_monitor_pkg::*;
(
    // clock, reset and bus
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // comparator and interrupt side
    input wire logic        channel1CompOut,
    input wire logic        channel1Enable,
    input wire logic        channel3Enable,
    input wire logic        channel1Request,
    input wire logic [2:0]  channel1Level
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // decoded access phases
    logic acc;
    logic wrCtl;
    logic rdCtl;
    logic wrIrq;
    logic mapped;
    assign acc    = psel && penable;
    assign wrCtl  = acc && pwrite && pstrb[0] && paddr == CONTROL_ADDR;
    assign rdCtl  = acc && !pwrite && paddr == CONTROL_ADDR;
    assign wrIrq  = acc && pwrite && paddr == IRQ_CONTROL_ADDR;
    assign mapped = paddr inside {CONTROL_ADDR, FILTER_ADDR, INPUT_ENABLE_ADDR,
                                  IRQ_CONTROL_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};

    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_err;
        acc |-> pslverr == !mapped;
    endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_en1;
        wrCtl && pwdata[0] |=> channel1Enable;
    endproperty
    a_en1: assert property (p_en1) else $error("channel 1 not enabled");
    property p_en3;
        wrCtl && !pwdata[4] |=> !channel3Enable;
    endproperty
    a_en3: assert property (p_en3) else $error("channel 3 not disabled");
    property p_flag_off;
        rdCtl && !channel1Enable |-> !prdata[CH1_RESULT_BIT];
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag set while off");
    // flag trails the comparator by the two synchronizer stages
    property p_sync;
        rdCtl && channel1Enable && $past(channel1Enable, 3)
            |-> prdata[CH1_RESULT_BIT] == $past(channel1CompOut, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("flag latency wrong");
    property p_req_hold;
        $fell(channel1Request) |-> $past(wrIrq);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request lost");
    property p_level;
        $changed(channel1Level) |-> $past(wrIrq);
    endproperty
    a_level: assert property (p_level) else $error("level changed alone");

    c_enable: cover property (wrCtl && pwdata[0]);
    c_request: cover property ($rose(channel1Request));
    c_refused: cover property (acc && pslverr);
endmodule : cmp_monitor_checker

bind cmp_monitor cmp_monitor_checker u_chk (.sys_clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .channel1CompOut,
    .channel1Enable, .channel3Enable, .channel1Request, .channel1Level);
`default_nettype wire

// File: cmp_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_analog_model
(
    // analog side as one bit
    input  wire logic enable,
    input  wire logic aboveRef,
    // comparator output
    output logic      compOut
);
    assign compOut = enable & aboveRef;
endmodule : cmp_analog_model
`default_nettype wire

// File: tb_dual_comparator_monitor_filter.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dual_comparator_monitor_filter
    import cmp_monitor_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, channel1CompOut, channel3CompOut, irq;
    logic        channel1Enable, channel3Enable, channel1Request, channel3Request;
    logic        above1 = 1'b0, above3 = 1'b0;
    logic [2:0]  channel1Level, channel3Level;
    int          n_fail = 0, total_checks = 0;
    typedef struct packed {logic [11:0] a; logic w; logic [31:0] d;} row_t;
    // reset values, masks, reserved and unmapped places
    row_t rows [16] = '{'{CONTROL_ADDR, 1'b0, 32'h0}, '{FILTER_ADDR, 1'b0, 32'h0},
        '{INPUT_ENABLE_ADDR, 1'b0, 32'h0}, '{IRQ_CONTROL_ADDR, 1'b0, 32'h0},
        '{IRQ_STATUS_ADDR, 1'b0, 32'h0}, '{IRQ_MASK_ADDR, 1'b0, 32'h0},
        '{FILTER_ADDR, 1'b1, 32'hFF}, '{FILTER_ADDR, 1'b0, 32'hCF},
        '{CONTROL_ADDR, 1'b1, 32'hFF}, '{CONTROL_ADDR, 1'b0, 32'h11},
        '{INPUT_ENABLE_ADDR, 1'b1, 32'h30}, '{INPUT_ENABLE_ADDR, 1'b0, 32'h0},
        '{IRQ_CONTROL_ADDR, 1'b1, 32'h1717}, '{IRQ_CONTROL_ADDR, 1'b0, 32'h1717},
        '{12'h100, 1'b1, 32'h5}, '{12'h100, 1'b0, 32'h0}};

    cmp_monitor dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .channel1CompOut, .channel3CompOut,
        .channel1Enable, .channel3Enable, .channel1Request, .channel3Request,
        .channel1Level, .channel3Level, .irq);
    cmp_analog_model m1 (.enable(channel1Enable), .aboveRef(above1),
        .compOut(channel1CompOut));
    cmp_analog_model m3 (.enable(channel3Enable), .aboveRef(above3),
        .compOut(channel3CompOut));

    // free running 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one transfer; the request stands until pready is sampled high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a stuck wait
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(r, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // bounded wait for a request flag to rise
    task automatic wait_req(input int ch, input int lim);
        int n;
        for (n = 0; n < lim && (ch == 1 ? channel1Request : channel3Request) !== 1'b1; n++)
            @(negedge sys_clk);
        chk(32'(ch == 1 ? channel1Request : channel3Request), 32'h1);
    endtask : wait_req

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // hang guard, far beyond the expected run of about 300 cycles
    initial
    begin
        #2000000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i])
            if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
            else rd(rows[i].a, rows[i].d);
        chk(32'(channel1Level), 32'h7);
        chk({channel1Enable, channel3Enable, channel3Level}, 32'h1F);
        $display("register table done");
        apb(FILTER_ADDR, 1'b1, 32'h0);
        apb(IRQ_CONTROL_ADDR, 1'b1, 32'h1212);
        apb(IRQ_STATUS_ADDR, 1'b1, 32'h3);
        apb(IRQ_MASK_ADDR, 1'b1, 32'h1);
        above1 <= 1'b1;
        tick(10);
        chk(32'(channel1Request), 32'h0);
        rd(CONTROL_ADDR, 32'h19);
        above1 <= 1'b0;
        apb(INPUT_ENABLE_ADDR, 1'b1, 32'h44);
        tick(1);
        chk(32'(channel1Request), 32'h1);
        apb(IRQ_CONTROL_ADDR, 1'b1, 32'h1212);
        apb(IRQ_STATUS_ADDR, 1'b1, 32'h3);
        above1 <= 1'b1;
        wait_req(1, 8);
        chk({irq, channel3Request}, 32'h2);
        rd(IRQ_STATUS_ADDR, 32'h1);
        apb(IRQ_MASK_ADDR, 1'b1, 32'h0);
        // the mask lands at the access edge; look once it has settled
        tick(1);
        chk(32'(irq), 32'h0);
        apb(IRQ_CONTROL_ADDR, 1'b1, 32'h1212);
        above1 <= 1'b0;
        tick(10);
        chk(32'(channel1Request), 32'h0);
        apb(IRQ_CONTROL_ADDR, 1'b1, 32'h0202);
        apb(INPUT_ENABLE_ADDR, 1'b1, 32'hCC);
        apb(IRQ_CONTROL_ADDR, 1'b1, 32'h0202);
        above1 <= 1'b1;
        wait_req(1, 8);
        $display("edge tests done");
        for (int f = 1; f < 4; f++)
        begin
            apb(FILTER_ADDR, 1'b1, 32'(f) << 6);
            apb(IRQ_CONTROL_ADDR, 1'b1, 32'h0202);
            above3 <= ~above3;
            tick(4);
            chk(32'(channel3Request), 32'h0);
            wait_req(3, 150);
        end
        $display("filter tests done");
        // write without byte lane 0 is ignored, then channel 3 switched off
        @(posedge sys_clk) pstrb <= 4'hE;
        apb(CONTROL_ADDR, 1'b1, 32'h01);
        pstrb <= 4'hF;
        rd(CONTROL_ADDR, 32'h99);
        apb(CONTROL_ADDR, 1'b1, 32'h01);
        rd(CONTROL_ADDR, 32'h09);
        $display("disable tests done");
        @(posedge sys_clk) reset_n <= 1'b0;
        @(posedge sys_clk) reset_n <= 1'b1;
        rd(CONTROL_ADDR, 32'h0);
        chk({channel1Request, channel1Level}, 32'h0);
        $display("second reset done");
        report_and_stop();
    end
endmodule : tb_dual_comparator_monitor_filter
`default_nettype wire
